// ### hw/imr_master.sv
// Purpose: I2C master sequencer with receive, acknowledge, stop, start and collision.
// Assumes: SCL and SDA are open-drain, pulled up outside; pins are asynchronous.
// Notes: Received bytes queue in a FIFO; CPU reads pop it.
//
// Overview of operation
// - Receive starts only from idle; receive request outside idle is ignored.
// - During reception SCL toggles per counter rollover, SDA shifts in.
// - After eighth falling edge: store byte, flags set, SCL held low, idle.
// - Buffer full sets on byte load, clears when CPU reads the last queued byte.
// - Overflow sets when a byte completes while buffer full still set.
// - Buffer write during any sequence sets write clash and is discarded.
// - Acknowledge start pulls SCL low and drives SDA with acknowledge value.
// - Ack: one period, release SCL, wait high, one period, SCL low, idle.
// - Stop: SDA low, count, release SCL, one period later release SDA.
// - SDA high with SCL high sets halt; a period later done, interrupt.
// - Released SCL suspends counter until sampled high, then reload and count.
// - Keeps working in sleep; completed events request wake when enabled.
// - Device reset disables the unit and aborts any transfer.
// - Floating SDA for a one but sampling zero flags collision, idle.
// - Collision in transmit halts it, clears buffer full unless received bytes remain queued, releases lines.
// - Collision in a sequence aborts it, releases lines, clears its enable.
// - After collision keep watching; interrupt when a bus stop appears.
// - New buffer write after collision transmits from the first bit.
// - Start with SDA or SCL already low aborts with collision.
// - Start counts from reload once SDA high; SCL low then is collision.
// - SDA low early asserts SDA early; else second count ends SCL low.
// - Counter reloads from seven bits, counts down to zero, twice per cycle.
`timescale 1ns/10ps

// =============================================================================
// Receive FIFO
module imr_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input logic clk,
   input logic sys_rst,
   input logic clk_en,
   input logic in_valid,
   output logic in_ready,
   input logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [$clog2(DEPTH+1)-1:0] level
);
   localparam int PTR_W = $clog2(DEPTH);
   localparam int CNT_W = $clog2(DEPTH+1);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PTR_W-1:0] wr_ptr;
      logic [PTR_W-1:0] rd_ptr;
      logic [CNT_W-1:0] count;
      logic valid;
      logic full;
   } imr_fifo_state_type;
   imr_fifo_state_type q, d;
   logic push;
   logic pop;
   logic [CNT_W-1:0] cnt_next;

   // Pointers wrap naturally, so DEPTH must be a power of two
   always_comb begin
      d = q;
      push = in_valid && !q.full;
      pop = out_ready && q.valid;
      if (push) begin
         d.mem[q.wr_ptr] = in_data;
         d.wr_ptr = q.wr_ptr + 1'b1;
      end
      if (pop) begin
         d.rd_ptr = q.rd_ptr + 1'b1;
      end
      cnt_next = q.count + CNT_W'(push) - CNT_W'(pop);
      d.count = cnt_next;
      d.valid = cnt_next != '0;
      d.full = cnt_next == CNT_W'(DEPTH);
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         q <= '0;
      end else if (clk_en) begin
         q <= d;
      end
   end

   assign in_ready = !q.full;
   assign out_valid = q.valid;
   assign out_data = q.mem[q.rd_ptr];
   assign level = q.count;
endmodule : imr_fifo

// =============================================================================
// Master sequencer
module imr_master
   import imr_pkg::*;
(
   input logic clk,
   input logic sys_rst,
   input logic clk_en,
   input logic scl_i,
   output logic scl_o,
   output logic scl_oe_n,
   input logic sda_i,
   output logic sda_o,
   output logic sda_oe_n,
   input logic ctl_wr,
   input logic [BYTE_W-1:0] ctl_wdata,
   input logic [BRG_W-1:0] reload_value,
   input logic buf_wr,
   input logic [BYTE_W-1:0] buf_wdata,
   output logic rd_valid,
   input logic rd_ready,
   output logic [BYTE_W-1:0] rd_data,
   input logic irq_clear,
   input logic collision_clear,
   input logic overflow_clear,
   input logic write_clash_clear,
   input logic sleep_mode,
   input logic irq_enable,
   output logic start_enable,
   output logic stop_enable,
   output logic receive_enable,
   output logic acknowledge_start,
   output logic acknowledge_value,
   output logic buffer_full,
   output logic overflow_flag,
   output logic write_clash_flag,
   output logic port_interrupt_flag,
   output logic collision_flag,
   output logic begin_detected,
   output logic halt_detected,
   output logic wake_request
);
   typedef struct packed {
      imr_phase_type st;
      logic scl_s1;
      logic scl_s2;
      logic sda_s1;
      logic sda_s2;
      logic scl_prev;
      logic sda_prev;
      logic scl_oe_n;
      logic sda_oe_n;
      logic [TICK_W-1:0] tick_cnt;
      logic [BRG_W-1:0] brg_cnt;
      logic brg_run;
      logic [3:0] bit_cnt;
      logic [BYTE_W-1:0] shift;
      logic tx_mode;
      logic tx_full;
      logic start_enable;
      logic stop_enable;
      logic receive_enable;
      logic acknowledge_start;
      logic ack_value;
      logic buffer_full;
      logic overflow;
      logic write_clash;
      logic port_irq;
      logic collision;
      logic begin_det;
      logic halt_det;
      logic watch;
      logic wake;
   } imr_state_type;
   imr_state_type q, d;
   logic tick;
   logic timeout;
   logic coll;
   logic rx_done;
   logic irq_set;
   logic halt_set;
   logic wclash_set;
   logic begin_ev;
   logic stop_ev;
   logic pop;
   logic fifo_ready;
   logic [BYTE_W-1:0] push_data;
   logic [FIFO_CNT_W-1:0] fifo_level;
   logic [FIFO_CNT_W-1:0] lvl_next;

   imr_fifo #(
      .WIDTH(BYTE_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .in_valid(rx_done),
      .in_ready(fifo_ready),
      .in_data(push_data),
      .out_valid(rd_valid),
      .out_ready(rd_ready),
      .out_data(rd_data),
      .level(fifo_level)
   );

   always_comb begin
      d = q;
      coll = 1'b0;
      rx_done = 1'b0;
      irq_set = 1'b0;
      halt_set = 1'b0;
      wclash_set = 1'b0;
      pop = rd_ready && rd_valid;
      push_data = {q.shift[BYTE_W-2:0], q.sda_s2};
      // Pins: second stage only feeds logic
      d.scl_s1 = scl_i;
      d.scl_s2 = q.scl_s1;
      d.sda_s1 = sda_i;
      d.sda_s2 = q.sda_s1;
      d.scl_prev = q.scl_s2;
      d.sda_prev = q.sda_s2;
      tick = q.tick_cnt == TICK_LAST;
      d.tick_cnt = tick ? '0 : q.tick_cnt + 1'b1;
      timeout = clk_en && tick && q.brg_run && q.brg_cnt == '0;
      if (q.brg_run && tick && q.brg_cnt != '0) begin
         d.brg_cnt = q.brg_cnt - 1'b1;
      end
      if (timeout) begin
         d.brg_run = 1'b0;
      end
      if (buf_wr && q.st != IMR_IDLE) begin
         wclash_set = 1'b1;
      end
      unique case (q.st)
         IMR_IDLE: begin
            if (buf_wr) begin
               d.shift = buf_wdata;
               d.tx_mode = 1'b1;
               d.tx_full = 1'b1;
               d.bit_cnt = '0;
               d.scl_oe_n = LINE_LOW_VALUE;
               d.brg_cnt = reload_value;
               d.brg_run = 1'b1;
               d.st = IMR_BIT_LOW;
            end else if (ctl_wr) begin
               d.ack_value = ctl_wdata[CTL_ACKVAL_BIT];
               if (ctl_wdata[CTL_START_BIT]) begin
                  d.start_enable = 1'b1;
                  if (!q.sda_s2 || !q.scl_s2) begin
                     coll = 1'b1;
                  end else begin
                     d.brg_cnt = reload_value;
                     d.brg_run = 1'b1;
                     d.st = IMR_START_A;
                  end
               end else if (ctl_wdata[CTL_STOP_BIT]) begin
                  d.stop_enable = 1'b1;
                  d.sda_oe_n = LINE_LOW_VALUE;
                  d.scl_oe_n = LINE_LOW_VALUE;
                  d.st = IMR_STOP_A;
               end else if (ctl_wdata[CTL_RCV_BIT] && fifo_ready) begin
                  d.receive_enable = 1'b1;
                  d.tx_mode = 1'b0;
                  d.bit_cnt = '0;
                  d.scl_oe_n = LINE_LOW_VALUE;
                  d.sda_oe_n = LINE_RELEASED;
                  d.brg_cnt = reload_value;
                  d.brg_run = 1'b1;
                  d.st = IMR_BIT_LOW;
               end else if (ctl_wdata[CTL_ACK_BIT]) begin
                  d.acknowledge_start = 1'b1;
                  d.scl_oe_n = LINE_LOW_VALUE;
                  d.sda_oe_n = ctl_wdata[CTL_ACKVAL_BIT];
                  d.brg_cnt = reload_value;
                  d.brg_run = 1'b1;
                  d.st = IMR_ACK_LOW;
               end
            end
         end
         IMR_START_A: begin
            if (!q.sda_s2 || timeout) begin
               d.sda_oe_n = LINE_LOW_VALUE;
               d.brg_cnt = reload_value;
               d.brg_run = 1'b1;
               d.st = IMR_START_B;
            end else if (!q.scl_s2) begin
               coll = 1'b1;
            end
         end
         IMR_START_B: begin
            if (timeout) begin
               d.scl_oe_n = LINE_LOW_VALUE;
               d.start_enable = 1'b0;
               irq_set = 1'b1;
               d.st = IMR_IDLE;
            end
         end
         IMR_BIT_LOW: begin
            d.sda_oe_n = (q.tx_mode && q.bit_cnt != ACK_BIT_IDX) ?
                         q.shift[BYTE_W-1] : LINE_RELEASED;
            if (timeout) begin
               d.scl_oe_n = LINE_RELEASED;
               d.st = IMR_BIT_WAIT;
            end
         end
         IMR_BIT_WAIT: begin
            if (q.scl_s2) begin
               d.brg_cnt = reload_value;
               d.brg_run = 1'b1;
               d.st = IMR_BIT_HIGH;
            end
         end
         IMR_BIT_HIGH: begin
            if (q.tx_mode && q.bit_cnt != ACK_BIT_IDX && q.sda_oe_n && !q.sda_s2) begin
               coll = 1'b1;
            end else if (timeout) begin
               d.scl_oe_n = LINE_LOW_VALUE;
               d.shift = push_data;
               d.bit_cnt = q.bit_cnt + 1'b1;
               if (!q.tx_mode && q.bit_cnt == LAST_BIT) begin
                  rx_done = 1'b1;
                  irq_set = 1'b1;
                  d.receive_enable = 1'b0;
                  d.st = IMR_IDLE;
               end else if (q.tx_mode && q.bit_cnt == ACK_BIT_IDX) begin
                  irq_set = 1'b1;
                  d.tx_mode = 1'b0;
                  d.st = IMR_IDLE;
               end else begin
                  if (q.tx_mode && q.bit_cnt == LAST_BIT) begin
                     d.tx_full = 1'b0;
                  end
                  d.brg_cnt = reload_value;
                  d.brg_run = 1'b1;
                  d.st = IMR_BIT_LOW;
               end
            end
         end
         IMR_ACK_LOW: begin
            if (timeout) begin
               d.scl_oe_n = LINE_RELEASED;
               d.st = IMR_ACK_WAIT;
            end
         end
         IMR_ACK_WAIT: begin
            if (q.scl_s2) begin
               d.brg_cnt = reload_value;
               d.brg_run = 1'b1;
               d.st = IMR_ACK_HIGH;
            end
         end
         IMR_ACK_HIGH: begin
            if (q.ack_value && !q.sda_s2) begin
               coll = 1'b1;
            end else if (timeout) begin
               d.scl_oe_n = LINE_LOW_VALUE;
               d.acknowledge_start = 1'b0;
               irq_set = 1'b1;
               d.st = IMR_IDLE;
            end
         end
         IMR_STOP_A: begin
            if (!q.sda_s2) begin
               d.brg_cnt = reload_value;
               d.brg_run = 1'b1;
               d.st = IMR_STOP_B;
            end
         end
         IMR_STOP_B: begin
            if (timeout) begin
               d.scl_oe_n = LINE_RELEASED;
               d.st = IMR_STOP_WAIT;
            end
         end
         IMR_STOP_WAIT: begin
            if (q.scl_s2) begin
               d.brg_cnt = reload_value;
               d.brg_run = 1'b1;
               d.st = IMR_STOP_C;
            end
         end
         IMR_STOP_C: begin
            if (timeout) begin
               d.sda_oe_n = LINE_RELEASED;
               d.st = IMR_STOP_D;
            end
         end
         IMR_STOP_D: begin
            if (q.sda_s2 && q.scl_s2) begin
               halt_set = 1'b1;
               d.brg_cnt = reload_value;
               d.brg_run = 1'b1;
               d.st = IMR_STOP_E;
            end
         end
         IMR_STOP_E: begin
            if (timeout) begin
               d.stop_enable = 1'b0;
               irq_set = 1'b1;
               d.st = IMR_IDLE;
            end
         end
         default: begin
            d.st = IMR_IDLE;
         end
      endcase
      begin_ev = q.sda_prev && !q.sda_s2 && q.scl_s2 && q.scl_prev;
      stop_ev = !q.sda_prev && q.sda_s2 && q.scl_s2 && q.scl_prev;
      if (begin_ev) begin
         d.begin_det = 1'b1;
         d.halt_det = 1'b0;
      end
      if (stop_ev || halt_set) begin
         d.begin_det = 1'b0;
         d.halt_det = 1'b1;
      end
      if (stop_ev && q.watch) begin
         irq_set = 1'b1;
         d.watch = 1'b0;
      end
      if (coll) begin
         d.st = IMR_IDLE;
         d.scl_oe_n = LINE_RELEASED;
         d.sda_oe_n = LINE_RELEASED;
         d.brg_run = 1'b0;
         d.start_enable = 1'b0;
         d.stop_enable = 1'b0;
         d.receive_enable = 1'b0;
         d.acknowledge_start = 1'b0;
         d.tx_mode = 1'b0;
         d.tx_full = 1'b0;
         d.watch = 1'b1;
      end
      // Sticky flags: a set in the clear cycle wins
      d.collision = (q.collision && !collision_clear) || coll;
      d.port_irq = (q.port_irq && !irq_clear) || irq_set;
      d.write_clash = (q.write_clash && !write_clash_clear) || wclash_set;
      d.overflow = (q.overflow && !overflow_clear) || (rx_done && q.buffer_full);
      d.wake = sleep_mode && irq_enable && irq_set;
      lvl_next = fifo_level + FIFO_CNT_W'(rx_done) - FIFO_CNT_W'(pop);
      d.buffer_full = d.tx_full || (lvl_next != '0);
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         q <= '0;
         q.scl_oe_n <= LINE_RELEASED;
         q.sda_oe_n <= LINE_RELEASED;
         q.scl_s1 <= 1'b1;
         q.scl_s2 <= 1'b1;
         q.sda_s1 <= 1'b1;
         q.sda_s2 <= 1'b1;
         q.scl_prev <= 1'b1;
         q.sda_prev <= 1'b1;
      end else if (clk_en) begin
         q <= d;
      end
   end

   assign scl_o = LINE_LOW_VALUE;
   assign sda_o = LINE_LOW_VALUE;
   assign scl_oe_n = q.scl_oe_n;
   assign sda_oe_n = q.sda_oe_n;
   assign start_enable = q.start_enable;
   assign stop_enable = q.stop_enable;
   assign receive_enable = q.receive_enable;
   assign acknowledge_start = q.acknowledge_start;
   assign acknowledge_value = q.ack_value;
   assign buffer_full = q.buffer_full;
   assign overflow_flag = q.overflow;
   assign write_clash_flag = q.write_clash;
   assign port_interrupt_flag = q.port_irq;
   assign collision_flag = q.collision;
   assign begin_detected = q.begin_det;
   assign halt_detected = q.halt_det;
   assign wake_request = q.wake;

   // ==========================================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence idle_low_s;
      q.st == IMR_IDLE && !q.scl_oe_n;
   endsequence

   rcv_busy_ignore_a: assert property (
      (clk_en && ctl_wr && ctl_wdata[CTL_RCV_BIT] && q.st != IMR_IDLE && !q.receive_enable)
      |=> !q.receive_enable) else $error("receive accepted outside idle");
   rx_done_flags_a: assert property (
      rx_done |=> idle_low_s ##0 (q.buffer_full && q.port_irq && !q.receive_enable && !q.brg_run))
      else $error("byte completion effects missing");
   ovf_set_a: assert property (
      (rx_done && q.buffer_full) |=> q.overflow) else $error("overflow not flagged");
   wclash_set_a: assert property (
      (clk_en && buf_wr && q.st != IMR_IDLE) |=> (q.write_clash && !q.tx_full)
      or (q.write_clash && $stable(q.tx_full))) else $error("busy write not flagged");
   ack_drive_a: assert property (
      q.st == IMR_ACK_LOW |-> (!q.scl_oe_n && q.sda_oe_n == q.ack_value))
      else $error("acknowledge drive wrong");
   ack_done_a: assert property (
      (q.st == IMR_ACK_HIGH && timeout && !coll) |=> idle_low_s ##0 !q.acknowledge_start)
      else $error("acknowledge end wrong");
   stretch_hold_a: assert property (
      (q.st == IMR_BIT_WAIT && !q.scl_s2) |=> $stable(q.brg_cnt))
      else $error("counter ran while SCL held");
   stretch_reload_a: assert property (
      (clk_en && q.st == IMR_BIT_WAIT && q.scl_s2) |=>
      (q.brg_run && q.brg_cnt == $past(reload_value))) else $error("no reload on SCL high");
   stop_release_a: assert property (
      (q.st == IMR_STOP_B && timeout) |=> (q.scl_oe_n && !q.sda_oe_n))
      else $error("stop SCL release wrong");
   stop_done_a: assert property (
      (q.st == IMR_STOP_E && timeout) |=> (!q.stop_enable && q.port_irq && q.halt_det))
      else $error("stop completion wrong");
   coll_release_a: assert property (
      coll |=> (q.collision && q.scl_oe_n && q.sda_oe_n && q.st == IMR_IDLE && !q.buffer_full
      || q.collision && q.scl_oe_n && q.sda_oe_n && q.st == IMR_IDLE && rd_valid))
      else $error("collision did not release bus");
   start_abort_a: assert property (
      (clk_en && q.st == IMR_IDLE && !buf_wr && ctl_wr && ctl_wdata[CTL_START_BIT]
      && (!q.sda_s2 || !q.scl_s2)) |=> (q.collision && !q.start_enable))
      else $error("start on busy lines not aborted");
endmodule : imr_master

// ### hw/imr_pkg.sv
// Purpose: Shared constants and types for the I2C master receive/ack/stop block.
// Assumes: Q-phase clock equals clk; TICK_CYCLES is a power of two.
// Notes: Control bit positions follow the second control register layout.
package imr_pkg;
   // ==========================================================================
   // Widths
   localparam int BYTE_W = 8;
   localparam int BRG_W = 7;
   localparam int FIFO_DEPTH = 32;
   localparam int FIFO_CNT_W = 6;

   // ==========================================================================
   // Control register bit positions
   localparam int CTL_START_BIT = 0;
   localparam int CTL_STOP_BIT = 2;
   localparam int CTL_RCV_BIT = 3;
   localparam int CTL_ACK_BIT = 4;
   localparam int CTL_ACKVAL_BIT = 5;

   // ==========================================================================
   // Rate counter timing: one decrement per two Q phases
   localparam int TICK_CYCLES = 2;
   localparam int TICK_W = 1;
   localparam logic [TICK_W-1:0] TICK_LAST = 1'h1;

   // ==========================================================================
   // Bit counts and line values
   localparam logic [3:0] LAST_BIT = 4'h7;
   localparam logic [3:0] ACK_BIT_IDX = 4'h8;
   localparam logic LINE_RELEASED = 1'b1;
   localparam logic LINE_LOW_VALUE = 1'b0;

   typedef enum logic [3:0] {
      IMR_IDLE, IMR_START_A, IMR_START_B, IMR_BIT_LOW, IMR_BIT_WAIT, IMR_BIT_HIGH,
      IMR_ACK_LOW, IMR_ACK_WAIT, IMR_ACK_HIGH, IMR_STOP_A, IMR_STOP_B, IMR_STOP_WAIT,
      IMR_STOP_C, IMR_STOP_D, IMR_STOP_E
   } imr_phase_type;
endpackage : imr_pkg

// ### tb/imr_slave.sv
// Purpose: I2C slave model that feeds one byte to the master receiver.
// Assumes: Open-drain wires with pull-ups; SCL comes from the master.
// Notes: Stretch holds SCL low 300 ns after each fall; sda_hold forces SDA low.
`timescale 1ns/10ps
module imr_slave (
   input wire logic scl,
   input wire logic arm,
   input wire logic [7:0] tx_byte,
   input wire logic stretch,
   input wire logic sda_hold,
   output logic scl_low,
   output logic sda_low
);
   int cnt;
   logic bit_low;
   assign sda_low = bit_low | sda_hold;
   initial begin
      cnt = 8;
      bit_low = 1'b0;
      scl_low = 1'b0;
   end
   // First bit must already sit on SDA when SCL is low at start
   always @(posedge arm) begin
      cnt = 0;
      bit_low = ~tx_byte[7];
   end
   always @(posedge scl) begin
      cnt = cnt + 1;
   end
   always @(negedge scl) begin
      bit_low = (cnt < 8) ? ~tx_byte[7 - cnt] : 1'b0;
      if (stretch) begin
         scl_low = 1'b1;
         #300;
         scl_low = 1'b0;
      end
   end
endmodule : imr_slave

// ### tb/tb_top.sv
// Purpose: Self-checking bench for the master receive, ack, stop and collision.
// Assumes: Reload value 2; inputs change on the falling edge.
// Notes: Clear strobes are pulsed together to keep the bench short.
`timescale 1ns/10ps
module tb_top;
   import imr_pkg::*;
   typedef struct packed {logic [7:0] b; logic a; logic st; logic sl;} imr_row_type;
   logic clk = 0, sys_rst = 1, ctl_wr = 0, buf_wr = 0, rd_ready = 0, clr = 0;
   logic sleep_mode = 0, arm = 0, stretch = 0, sda_hold = 0, wake_seen = 0;
   logic [7:0] ctl_wdata = 8'h00, tx_byte = 8'h00;
   logic scl_oe_n, sda_oe_n, scl_low, sda_low, rd_valid, start_enable, stop_enable;
   logic receive_enable, acknowledge_start, buffer_full, overflow_flag;
   logic write_clash_flag, port_interrupt_flag, collision_flag, halt_detected;
   logic wake_request;
   logic [7:0] rd_data;
   int err_total = 0, n_tests = 0;
   imr_row_type rows [4] = '{'{8'hA5, 1'h0, 1'h0, 1'h0}, '{8'h5A, 1'h1, 1'h1, 1'h0},
                            '{8'hFF, 1'h0, 1'h0, 1'h1}, '{8'h00, 1'h1, 1'h0, 1'h0}};
   // Open-drain wires with pull-ups
   wire scl = ~(~scl_oe_n | scl_low);
   wire sda = ~(~sda_oe_n | sda_low);
   imr_slave u_slave (.scl(scl), .arm(arm), .tx_byte(tx_byte), .stretch(stretch),
      .sda_hold(sda_hold), .scl_low(scl_low), .sda_low(sda_low));
   imr_master u_dut (.clk(clk), .sys_rst(sys_rst), .clk_en(1'b1), .scl_i(scl), .scl_o(),
      .scl_oe_n(scl_oe_n), .sda_i(sda), .sda_o(), .sda_oe_n(sda_oe_n), .ctl_wr(ctl_wr),
      .ctl_wdata(ctl_wdata), .reload_value(7'h02), .buf_wr(buf_wr), .buf_wdata(8'h11),
      .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data), .irq_clear(clr),
      .collision_clear(clr), .overflow_clear(clr), .write_clash_clear(clr),
      .sleep_mode(sleep_mode), .irq_enable(1'b1), .start_enable(start_enable),
      .stop_enable(stop_enable), .receive_enable(receive_enable),
      .acknowledge_start(acknowledge_start), .acknowledge_value(),
      .buffer_full(buffer_full), .overflow_flag(overflow_flag),
      .write_clash_flag(write_clash_flag), .port_interrupt_flag(port_interrupt_flag),
      .collision_flag(collision_flag), .begin_detected(), .halt_detected(halt_detected),
      .wake_request(wake_request));
   initial begin
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (wake_request === 1'b1) wake_seen <= 1'b1;
   end
   // =========================================================================
   // Shared tasks
   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : stop_test
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
   endtask : pulse
   task automatic ctl(input logic [7:0] v);
      ctl_wdata = v;
      pulse(ctl_wr);
   endtask : ctl
   task automatic wait_done(ref logic s);
      for (int i = 0; i < 4000 && s !== 1'b0; i++) @(negedge clk);
      if (s !== 1'b0) begin
         err_total++;
         stop_test();
      end
   endtask : wait_done
   task automatic rx_go(input logic [7:0] b);
      tx_byte = b;
      pulse(arm);
      ctl(8'h08);
   endtask : rx_go
   task automatic rx(input logic [7:0] b);
      rx_go(b);
      wait_done(receive_enable);
   endtask : rx
   // =========================================================================
   // Main sequence
   initial begin
      repeat (5) @(negedge clk);
      sys_rst = 1'b0;
      repeat (4) @(negedge clk);
      foreach (rows[i]) begin
         stretch = rows[i].st;
         sleep_mode = rows[i].sl;
         wake_seen = 1'b0;
         rx(rows[i].b);
         chk("irq", port_interrupt_flag, 8'h01);
         chk("scl_held", scl_oe_n, 8'h00);
         chk("full", buffer_full, 8'h01);
         chk("data", rd_data, rows[i].b);
         chk("wake", wake_seen | wake_request, rows[i].sl);
         pulse(rd_ready);
         chk("empty", buffer_full, 8'h00);
         ctl({2'h0, rows[i].a, 5'h10});
         wait_done(acknowledge_start);
         chk("ack_sda", sda_oe_n, rows[i].a);
         chk("ack_scl", scl_oe_n, 8'h00);
         pulse(clr);
         $display("row %0d done", i);
      end
      stretch = 1'b0;
      sleep_mode = 1'b0;
      rx_go(8'hC3);
      pulse(buf_wr);
      ctl(8'h04);
      chk("stop_refused", stop_enable, 8'h00);
      chk("clash", write_clash_flag, 8'h01);
      wait_done(receive_enable);
      for (int i = 1; i < 32; i++) rx(8'(i));
      chk("overflow", overflow_flag, 8'h01);
      ctl(8'h08);
      chk("full_refused", receive_enable, 8'h00);
      for (int i = 0; i < 32; i++) begin
         chk("fifo", rd_data, (i == 0) ? 8'hC3 : 8'(i));
         pulse(rd_ready);
         // One idle edge between reads
         @(negedge clk);
      end
      chk("drained", rd_valid, 8'h00);
      $display("fifo test done");
      pulse(clr);
      ctl(8'h04);
      @(negedge clk);
      ctl(8'h08);
      chk("busy_rcv", receive_enable, 8'h00);
      wait_done(stop_enable);
      chk("halt", halt_detected, 8'h01);
      chk("stop_irq", port_interrupt_flag, 8'h01);
      chk("stop_lines", {sda_oe_n, scl_oe_n}, 8'h03);
      $display("stop test done");
      sda_hold = 1'b1;
      repeat (4) @(negedge clk);
      pulse(clr);
      ctl(8'h01);
      chk("start_coll", collision_flag, 8'h01);
      chk("start_en", start_enable, 8'h00);
      pulse(clr);
      sda_hold = 1'b0;
      repeat (4) @(negedge clk);
      chk("bus_stop_irq", port_interrupt_flag, 8'h01);
      $display("start collision done");
      pulse(clr);
      sda_hold = 1'b1;
      ctl(8'h30);
      wait_done(acknowledge_start);
      chk("ack_coll", collision_flag, 8'h01);
      chk("ack_lines", {sda_oe_n, scl_oe_n}, 8'h03);
      sda_hold = 1'b0;
      $display("ack collision done");
      repeat (4) @(negedge clk);
      chk("bus_free", halt_detected, 8'h01);
      pulse(clr);
      // Bus seen free, so a fresh start is legal
      ctl(8'h01);
      wait_done(start_enable);
      chk("start_ok", {collision_flag, sda_oe_n, scl_oe_n}, 8'h00);
      sda_hold = 1'b1;
      pulse(buf_wr);
      chk("tx_full", buffer_full, 8'h01);
      wait_done(buffer_full);
      chk("tx_coll", {collision_flag, sda_oe_n, scl_oe_n}, 8'h07);
      sda_hold = 1'b0;
      repeat (4) @(negedge clk);
      pulse(clr);
      pulse(buf_wr);
      wait_done(buffer_full);
      chk("tx_restart", collision_flag, 8'h00);
      repeat (40) @(negedge clk);
      $display("start and transmit done");
      rx_go(8'h99);
      repeat (20) @(negedge clk);
      sys_rst = 1'b1;
      @(negedge clk);
      chk("rst_rx", {receive_enable, scl_oe_n, rd_valid}, 8'h02);
      $display("reset test done");
      stop_test();
   end
endmodule : tb_top
